// ==== src/mfmove_unit.sv ====
// move-from execution unit with AXI4-Lite control registers
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE1: system-control read, low word sign-extended
// RULE2: subindex zero for single-variant registers
// RULE3: only existing system-control registers named
// RULE4: fp word move, bits 31..0 sign-extended
// RULE5: custom coprocessor word move sign-extended
// RULE6: fp upper move, bits 63..32 sign-extended
// RULE7: no odd fp source when width bit 0
// RULE8: upper moves reserved before second release
// RULE9: custom upper move, bits 63..32 sign-extended
// RULE10: custom upper only on 64-bit registers
// RULE11: upper product copied, no exception
// RULE12: bottom product copied, no exception
// RULE13: product value correct despite later writes
// RULE14: fp register copy, both halves for paired
// RULE15: fp copy never sets cause or flags
// RULE16: valid fp indices and format from software
// RULE17: no paired copy in 16-register mode
// RULE18: disabled coprocessor raises unusable, no write
module mfmove_unit (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 INSTR_VALID,
  input  wire logic [31:0]          INSTR,
  output logic      [4:0]           SC_IDX,
  output logic      [2:0]           SC_SEL,
  input  wire logic [63:0]          SC_RDATA,
  output logic      [4:0]           FP_IDX,
  input  wire logic [63:0]          FP_RDATA,
  output logic      [15:0]          CC_IMPL,
  input  wire logic [63:0]          CC_RDATA,
  input  wire logic [63:0]          PROD_UPPER,
  input  wire logic [63:0]          PROD_BOTTOM,
  output mfmove_pkg::reg_wr_t       GPR_WR,
  output mfmove_pkg::reg_wr_t       FPR_WR,
  output mfmove_pkg::exc_t          EXC,
  output logic                      FP_CAUSE_WE,
  output logic                      IRQ,
  input  wire logic [7:0]           AWADDR,
  input  wire logic                 AWVALID,
  output logic                      AWREADY,
  input  wire logic [31:0]          WDATA,
  input  wire logic [3:0]           WSTRB,
  input  wire logic                 WVALID,
  output logic                      WREADY,
  output logic      [1:0]           BRESP,
  output logic                      BVALID,
  input  wire logic                 BREADY,
  input  wire logic [7:0]           ARADDR,
  input  wire logic                 ARVALID,
  output logic                      ARREADY,
  output logic      [31:0]          RDATA,
  output logic      [1:0]           RRESP,
  output logic                      RVALID,
  input  wire logic                 RREADY
);

  function automatic mfmove_pkg::op_t decode(input mfmove_pkg::instr_t i);
    mfmove_pkg::op_t op;
    op = mfmove_pkg::OP_NONE;
    case (i.opc)
      mfmove_pkg::OPC_SPECIAL: begin
        if (i.fn == mfmove_pkg::FN_UPPER) op = mfmove_pkg::OP_PHI;
        else if (i.fn == mfmove_pkg::FN_BOTTOM) op = mfmove_pkg::OP_PLO;
      end
      mfmove_pkg::OPC_SYSCTL: begin
        if (i.sub == mfmove_pkg::SUB_WORD) op = mfmove_pkg::OP_SC;
      end
      mfmove_pkg::OPC_FPU: begin
        if (i.sub == mfmove_pkg::SUB_WORD) op = mfmove_pkg::OP_FPW;
        else if (i.sub == mfmove_pkg::SUB_UPPER) op = mfmove_pkg::OP_FPH;
        else if (i.fn == mfmove_pkg::FN_FMOV) begin
          if (i.sub == mfmove_pkg::FMT_S || i.sub == mfmove_pkg::FMT_D ||
              i.sub == mfmove_pkg::FMT_PS) op = mfmove_pkg::OP_FMOV;
          else op = mfmove_pkg::OP_BADFMT;
        end
      end
      mfmove_pkg::OPC_CUSTOM: begin
        if (i.sub == mfmove_pkg::SUB_WORD) op = mfmove_pkg::OP_CCW;
        else if (i.sub == mfmove_pkg::SUB_UPPER) op = mfmove_pkg::OP_CCH;
      end
      default: op = mfmove_pkg::OP_NONE;
    endcase
    return op;
  endfunction

  function automatic logic [63:0] sext(input logic [31:0] w);
    return {{32{w[31]}}, w};
  endfunction

  // decode stage
  logic                    s1_valid;
  mfmove_pkg::instr_t      s1_ins;
  mfmove_pkg::op_t         s1_op;
  logic [mfmove_pkg::CTRL_W-1:0] ctrl;
  logic [mfmove_pkg::IRQ_W-1:0]  stat;
  logic [mfmove_pkg::IRQ_W-1:0]  mask;
  logic [31:0]             last;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s1_valid <= 1'b0;
      s1_ins   <= '0;
      s1_op    <= mfmove_pkg::OP_NONE;
    end else begin
      s1_valid <= INSTR_VALID;
      s1_ins   <= INSTR;
      s1_op    <= decode(INSTR);
    end
  end

  // read ports to the register files
  assign SC_IDX  = s1_ins.dst;
  assign SC_SEL  = s1_ins.fn[2:0];
  assign FP_IDX  = s1_ins.dst;
  assign CC_IMPL = {s1_ins.dst, s1_ins.sh, s1_ins.fn};

  // execute stage
  mfmove_pkg::reg_wr_t next_gpr;
  mfmove_pkg::reg_wr_t next_fpr;
  mfmove_pkg::exc_t    next_exc;
  logic                is_upper;
  logic                unit_off;

  always_comb begin
    next_gpr = '0;
    next_fpr = '0;
    next_exc = '0;
    is_upper = s1_op == mfmove_pkg::OP_FPH || s1_op == mfmove_pkg::OP_CCH;
    case (s1_op)
      mfmove_pkg::OP_SC: unit_off = !ctrl[mfmove_pkg::CTRL_CU0];
      mfmove_pkg::OP_FPW, mfmove_pkg::OP_FPH, mfmove_pkg::OP_FMOV:
        unit_off = !ctrl[mfmove_pkg::CTRL_CU1];
      mfmove_pkg::OP_CCW, mfmove_pkg::OP_CCH:
        unit_off = !ctrl[mfmove_pkg::CTRL_CU2];
      default: unit_off = 1'b0;
    endcase
    next_gpr.idx = (s1_op == mfmove_pkg::OP_PHI || s1_op == mfmove_pkg::OP_PLO) ?
                   s1_ins.dst : s1_ins.tgt; // RULE11 RULE12
    next_fpr.idx = s1_ins.sh;
    if (s1_valid && s1_op != mfmove_pkg::OP_NONE) begin
      if ((is_upper && !ctrl[mfmove_pkg::CTRL_REL2]) ||
          s1_op == mfmove_pkg::OP_BADFMT) begin
        next_exc.reserved = 1'b1; // RULE8
      end else if (unit_off) begin
        next_exc.unusable = 1'b1; // RULE18
      end else begin
        next_gpr.en = s1_op != mfmove_pkg::OP_FMOV;
        case (s1_op)
          mfmove_pkg::OP_SC:  next_gpr.data = sext(SC_RDATA[31:0]); // RULE1
          mfmove_pkg::OP_FPW: next_gpr.data = sext(FP_RDATA[31:0]); // RULE4
          mfmove_pkg::OP_FPH: next_gpr.data = sext(FP_RDATA[63:32]); // RULE6
          mfmove_pkg::OP_CCW: next_gpr.data = sext(CC_RDATA[31:0]); // RULE5
          mfmove_pkg::OP_CCH: next_gpr.data = sext(CC_RDATA[63:32]); // RULE9
          mfmove_pkg::OP_PHI: next_gpr.data = PROD_UPPER; // RULE11 RULE13
          mfmove_pkg::OP_PLO: next_gpr.data = PROD_BOTTOM; // RULE12 RULE13
          mfmove_pkg::OP_FMOV: begin
            next_fpr.en   = 1'b1; // RULE14
            next_fpr.data = FP_RDATA;
          end
          default: next_gpr.en = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      GPR_WR <= '0;
      FPR_WR <= '0;
      EXC    <= '0;
    end else begin
      GPR_WR <= next_gpr;
      FPR_WR <= next_fpr;
      EXC    <= next_exc;
    end
  end

  assign FP_CAUSE_WE = 1'b0; // RULE15

  // register bus
  logic        aw_hold;
  logic [7:0]  aw_addr;
  logic        w_hold;
  logic [31:0] w_data;
  logic        w_lane0;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        next_aw_hold;
  logic [7:0]  next_aw_addr;
  logic        next_w_hold;
  logic [31:0] next_w_data;
  logic        next_w_lane0;
  logic [1:0]  next_bresp;
  logic        next_bvalid;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [mfmove_pkg::CTRL_W-1:0] next_ctrl;
  logic [mfmove_pkg::IRQ_W-1:0]  next_stat;
  logic [mfmove_pkg::IRQ_W-1:0]  next_mask;
  logic [31:0] next_last;
  logic        do_wr;

  assign AWREADY = !aw_hold && !bvalid;
  assign WREADY  = !w_hold && !bvalid;
  assign ARREADY = !rvalid;
  assign BVALID  = bvalid;
  assign BRESP   = bresp;
  assign RVALID  = rvalid;
  assign RDATA   = rdata;
  assign RRESP   = rresp;
  assign IRQ     = |(stat & mask);

  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bresp   = bresp;
    next_bvalid  = bvalid;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_ctrl    = ctrl;
    next_mask    = mask;
    next_last    = GPR_WR.en ? GPR_WR.data[31:0] : last;
    next_stat    = stat;
    if (AWVALID && AWREADY) begin
      next_aw_hold = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_w_hold  = 1'b1;
      next_w_data  = WDATA;
      next_w_lane0 = WSTRB[0];
    end
    do_wr = aw_hold && w_hold && !bvalid;
    if (do_wr) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mfmove_pkg::RESP_OKAY;
      case (aw_addr)
        mfmove_pkg::ADDR_CTRL:
          if (w_lane0) next_ctrl = w_data[mfmove_pkg::CTRL_W-1:0];
        mfmove_pkg::ADDR_STAT:
          if (w_lane0) next_stat = stat & ~w_data[mfmove_pkg::IRQ_W-1:0];
        mfmove_pkg::ADDR_MASK:
          if (w_lane0) next_mask = w_data[mfmove_pkg::IRQ_W-1:0];
        mfmove_pkg::ADDR_LAST: next_bresp = mfmove_pkg::RESP_OKAY;
        default: next_bresp = mfmove_pkg::RESP_SLVERR;
      endcase
    end
    // hardware set wins over software clear
    next_stat[mfmove_pkg::IRQ_RSV]   = next_stat[mfmove_pkg::IRQ_RSV] | EXC.reserved;
    next_stat[mfmove_pkg::IRQ_UNUSE] = next_stat[mfmove_pkg::IRQ_UNUSE] | EXC.unusable;
    next_stat[mfmove_pkg::IRQ_DONE]  = next_stat[mfmove_pkg::IRQ_DONE] |
                                       GPR_WR.en | FPR_WR.en;
    if (bvalid && BREADY) next_bvalid = 1'b0;
    if (rvalid && RREADY) next_rvalid = 1'b0;
    if (ARVALID && ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp  = mfmove_pkg::RESP_OKAY;
      next_rdata  = '0;
      case (ARADDR)
        mfmove_pkg::ADDR_CTRL: next_rdata[mfmove_pkg::CTRL_W-1:0] = ctrl;
        mfmove_pkg::ADDR_STAT: next_rdata[mfmove_pkg::IRQ_W-1:0] = stat;
        mfmove_pkg::ADDR_MASK: next_rdata[mfmove_pkg::IRQ_W-1:0] = mask;
        mfmove_pkg::ADDR_LAST: next_rdata = last;
        default: next_rresp = mfmove_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold  <= 1'b0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
      bresp   <= mfmove_pkg::RESP_OKAY;
      bvalid  <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= mfmove_pkg::RESP_OKAY;
      ctrl    <= mfmove_pkg::CTRL_RESET;
      stat    <= '0;
      mask    <= '0;
      last    <= '0;
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold  <= next_w_hold;
      w_data  <= next_w_data;
      w_lane0 <= next_w_lane0;
      bresp   <= next_bresp;
      bvalid  <= next_bvalid;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      ctrl    <= next_ctrl;
      stat    <= next_stat;
      mask    <= next_mask;
      last    <= next_last;
    end
  end

  // checks
  logic go;
  assign go = s1_valid && !next_exc.reserved && !next_exc.unusable;

  sequence s_exec(mfmove_pkg::op_t k);
    go && s1_op == k;
  endsequence

  property p_sysctl;
    @(posedge CLK) disable iff (RESET)
    s_exec(mfmove_pkg::OP_SC) |=> GPR_WR.en && GPR_WR.data == sext($past(SC_RDATA[31:0]));
  endproperty
  a_sysctl: assert property (p_sysctl) else $error("system-control move wrong"); // RULE1

  property p_fpw;
    @(posedge CLK) disable iff (RESET)
    s_exec(mfmove_pkg::OP_FPW) |=> GPR_WR.data == sext($past(FP_RDATA[31:0]));
  endproperty
  a_fpw: assert property (p_fpw) else $error("fp word move wrong"); // RULE4

  property p_ccw;
    @(posedge CLK) disable iff (RESET)
    s_exec(mfmove_pkg::OP_CCW) |=> GPR_WR.data == sext($past(CC_RDATA[31:0]));
  endproperty
  a_ccw: assert property (p_ccw) else $error("custom word move wrong"); // RULE5

  property p_fph;
    @(posedge CLK) disable iff (RESET)
    s_exec(mfmove_pkg::OP_FPH) |=> GPR_WR.en && GPR_WR.data == sext($past(FP_RDATA[63:32]));
  endproperty
  a_fph: assert property (p_fph) else $error("fp upper move wrong"); // RULE6

  property p_rel;
    @(posedge CLK) disable iff (RESET)
    s1_valid && is_upper && !ctrl[mfmove_pkg::CTRL_REL2] |=> EXC.reserved && !GPR_WR.en;
  endproperty
  a_rel: assert property (p_rel) else $error("upper move not reserved"); // RULE8

  property p_cch;
    @(posedge CLK) disable iff (RESET)
    s_exec(mfmove_pkg::OP_CCH) |=> GPR_WR.data == sext($past(CC_RDATA[63:32]));
  endproperty
  a_cch: assert property (p_cch) else $error("custom upper move wrong"); // RULE9

  property p_phi;
    @(posedge CLK) disable iff (RESET)
    s_exec(mfmove_pkg::OP_PHI) |=> GPR_WR.en && GPR_WR.data == $past(PROD_UPPER) &&
      GPR_WR.idx == $past(s1_ins.dst) && EXC == '0;
  endproperty
  a_phi: assert property (p_phi) else $error("upper product move wrong"); // RULE11

  property p_plo;
    @(posedge CLK) disable iff (RESET)
    s_exec(mfmove_pkg::OP_PLO) |=> GPR_WR.en && GPR_WR.data == $past(PROD_BOTTOM) &&
      GPR_WR.idx == $past(s1_ins.dst) && EXC == '0;
  endproperty
  a_plo: assert property (p_plo) else $error("bottom product move wrong"); // RULE12

  property p_fmov;
    @(posedge CLK) disable iff (RESET)
    s_exec(mfmove_pkg::OP_FMOV) |=> FPR_WR.en && !GPR_WR.en && FPR_WR.data == $past(FP_RDATA);
  endproperty
  a_fmov: assert property (p_fmov) else $error("fp copy wrong"); // RULE14

  property p_nocause;
    @(posedge CLK) disable iff (RESET)
    FPR_WR.en |-> !FP_CAUSE_WE && !EXC.reserved;
  endproperty
  a_nocause: assert property (p_nocause) else $error("fp copy raised cause"); // RULE15

  property p_unuse;
    @(posedge CLK) disable iff (RESET)
    s1_valid && s1_op == mfmove_pkg::OP_SC && !ctrl[mfmove_pkg::CTRL_CU0]
      |=> EXC.unusable && !GPR_WR.en ##1 stat[mfmove_pkg::IRQ_UNUSE];
  endproperty
  a_unuse: assert property (p_unuse) else $error("unusable not raised"); // RULE18

endmodule // mfmove_unit
`default_nettype wire

// ==== src/mfmove_pkg.sv ====
// shared constants and types for the move-from execution unit
package mfmove_pkg;
  // major opcodes
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] OPC_SYSCTL  = 6'h10;
  localparam logic [5:0] OPC_FPU     = 6'h11;
  localparam logic [5:0] OPC_CUSTOM  = 6'h12;
  // sub-operation and format codes
  localparam logic [4:0] SUB_WORD    = 5'h00;
  localparam logic [4:0] SUB_UPPER   = 5'h03;
  localparam logic [4:0] FMT_S       = 5'h10;
  localparam logic [4:0] FMT_D       = 5'h11;
  localparam logic [4:0] FMT_PS      = 5'h16;
  // function codes
  localparam logic [5:0] FN_UPPER    = 6'h10;
  localparam logic [5:0] FN_BOTTOM   = 6'h12;
  localparam logic [5:0] FN_FMOV     = 6'h06;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STAT   = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_LAST   = 8'h0C;
  // control bits
  localparam int CTRL_W    = 5;
  localparam int CTRL_CU0  = 0;
  localparam int CTRL_CU1  = 1;
  localparam int CTRL_CU2  = 2;
  localparam int CTRL_FR   = 3;
  localparam int CTRL_REL2 = 4;
  localparam logic [4:0] CTRL_RESET = 5'h17;
  // interrupt bits
  localparam int IRQ_W     = 3;
  localparam int IRQ_RSV   = 0;
  localparam int IRQ_UNUSE = 1;
  localparam int IRQ_DONE  = 2;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [5:0] opc;
    logic [4:0] sub;
    logic [4:0] tgt;
    logic [4:0] dst;
    logic [4:0] sh;
    logic [5:0] fn;
  } instr_t;

  typedef enum {OP_NONE, OP_SC, OP_FPW, OP_FPH, OP_CCW, OP_CCH,
                OP_PHI, OP_PLO, OP_FMOV, OP_BADFMT} op_t;

  typedef struct packed {
    logic        en;
    logic [4:0]  idx;
    logic [63:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic reserved;
    logic unusable;
  } exc_t;
endpackage

// ==== sim/copro_model.sv ====
// far-side register files answering the move unit's reads
`timescale 1ns/10ps
`default_nettype none
module copro_model (
  input  wire logic [4:0]  SC_IDX,
  input  wire logic [2:0]  SC_SEL,
  input  wire logic [4:0]  FP_IDX,
  input  wire logic [15:0] CC_IMPL,
  output logic      [63:0] SC_RDATA,
  output logic      [63:0] FP_RDATA,
  output logic      [63:0] CC_RDATA
);
  logic [63:0] sc [256];
  logic [63:0] fp [32];
  logic [63:0] cc [32];
  // every index and subindex pair is backed
  assign SC_RDATA = sc[{SC_SEL, SC_IDX}];
  assign FP_RDATA = fp[FP_IDX];
  // all selector bits folded to pick a 64-bit register
  assign CC_RDATA = cc[CC_IMPL[4:0] ^ CC_IMPL[9:5] ^ CC_IMPL[14:10] ^ {4'h0, CC_IMPL[15]}];
endmodule // copro_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the move-from execution unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic                CLK, RESET, INSTR_VALID, FP_CAUSE_WE, IRQ;
  logic [31:0]         INSTR, WDATA, RDATA, last;
  logic [4:0]          SC_IDX, FP_IDX;
  logic [2:0]          SC_SEL;
  logic [15:0]         CC_IMPL;
  logic [63:0]         SC_RDATA, FP_RDATA, CC_RDATA, PROD_UPPER, PROD_BOTTOM;
  mfmove_pkg::reg_wr_t GPR_WR, FPR_WR;
  mfmove_pkg::exc_t    EXC;
  logic [7:0]          AWADDR, ARADDR;
  logic [3:0]          WSTRB;
  logic [1:0]          BRESP, RRESP;
  logic                AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic                ARVALID, ARREADY, RVALID, RREADY;
  int                  error_cnt, checks, cyc;

  mfmove_unit dut_u (
    .CLK(CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .SC_IDX(SC_IDX), .SC_SEL(SC_SEL), .SC_RDATA(SC_RDATA), .FP_IDX(FP_IDX),
    .FP_RDATA(FP_RDATA), .CC_IMPL(CC_IMPL), .CC_RDATA(CC_RDATA),
    .PROD_UPPER(PROD_UPPER), .PROD_BOTTOM(PROD_BOTTOM), .GPR_WR(GPR_WR),
    .FPR_WR(FPR_WR), .EXC(EXC), .FP_CAUSE_WE(FP_CAUSE_WE), .IRQ(IRQ),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY)
  );

  copro_model pm_u (
    .SC_IDX(SC_IDX), .SC_SEL(SC_SEL), .FP_IDX(FP_IDX), .CC_IMPL(CC_IMPL),
    .SC_RDATA(SC_RDATA), .FP_RDATA(FP_RDATA), .CC_RDATA(CC_RDATA)
  );

  initial CLK = 1'b0;
  always #2 CLK = ~CLK;

  task automatic summarize;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  function automatic logic [63:0] sx(input logic [31:0] w);
    return {{32{w[31]}}, w};
  endfunction

  task automatic chk_wr(input mfmove_pkg::reg_wr_t g, e);
    checks++;
    if (e.en ? (g !== e) : (g.en !== 1'b0)) begin
      error_cnt++;
      $display("unexpected write at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_w(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    ta = 1'b0;
    tw = 1'b0;
    tb = 1'b0;
    @(posedge CLK);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge CLK);
      ta = ta | AWREADY;
      tw = tw | WREADY;
      @(posedge CLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
    end
    while (!tb) begin
      @(negedge CLK);
      tb = BVALID;
      r  = BRESP;
      @(posedge CLK);
    end
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    t = 1'b0;
    @(posedge CLK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    while (!t) begin
      @(negedge CLK);
      t = ARREADY;
      @(posedge CLK);
    end
    ARVALID <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge CLK);
      t = RVALID;
      d = RDATA;
      r = RRESP;
      @(posedge CLK);
    end
    RREADY <= 1'b0;
  endtask

  // kinds: 0 sys, 1 fp word, 2 fp upper, 3 custom, 4 custom upper, 5/6 product, 7-9 copy
  task automatic build(input int k, output logic [31:0] i,
                       output mfmove_pkg::reg_wr_t eg, ef);
    logic [4:0]  t, a, e, d, f, n;
    logic [2:0]  s;
    logic [15:0] m;
    logic [63:0] v;
    t = 5'($urandom);
    a = 5'($urandom);
    d = 5'($urandom);
    s = 3'($urandom);
    m = 16'($urandom);
    e = {a[4:1], 1'b0};
    n = m[4:0] ^ m[9:5] ^ m[14:10] ^ {4'h0, m[15]};
    f = (k == 7) ? mfmove_pkg::FMT_S : (k == 8) ? mfmove_pkg::FMT_D : mfmove_pkg::FMT_PS;
    case (k)
      0: {i, v} = {mfmove_pkg::OPC_SYSCTL, mfmove_pkg::SUB_WORD, t, a, 8'h00, s,
                   sx(pm_u.sc[{s, a}][31:0])};
      1: {i, v} = {mfmove_pkg::OPC_FPU, mfmove_pkg::SUB_WORD, t, a, 11'h000,
                   sx(pm_u.fp[a][31:0])};
      2: {i, v} = {mfmove_pkg::OPC_FPU, mfmove_pkg::SUB_UPPER, t, e, 11'h000,
                   sx(pm_u.fp[e][63:32])};
      3: {i, v} = {mfmove_pkg::OPC_CUSTOM, mfmove_pkg::SUB_WORD, t, m,
                   sx(pm_u.cc[n][31:0])};
      4: {i, v} = {mfmove_pkg::OPC_CUSTOM, mfmove_pkg::SUB_UPPER, t, m,
                   sx(pm_u.cc[n][63:32])};
      5: {i, v} = {mfmove_pkg::OPC_SPECIAL, 10'h000, t, 5'h00, mfmove_pkg::FN_UPPER,
                   PROD_UPPER};
      6: {i, v} = {mfmove_pkg::OPC_SPECIAL, 10'h000, t, 5'h00, mfmove_pkg::FN_BOTTOM,
                   PROD_BOTTOM};
      default: {i, v} = {mfmove_pkg::OPC_FPU, f, 5'h00, a, d, mfmove_pkg::FN_FMOV,
                         pm_u.fp[a]};
    endcase
    eg = {k < 7, t, v};
    ef = {k > 6, d, v};
  endtask

  task automatic do_op(input logic [31:0] i, input mfmove_pkg::reg_wr_t eg, ef,
                       input logic [1:0] ee);
    @(posedge CLK);
    INSTR       <= i;
    INSTR_VALID <= 1'b1;
    @(posedge CLK);
    INSTR_VALID <= 1'b0;
    @(posedge CLK);
    PROD_UPPER  <= {$urandom, $urandom};
    PROD_BOTTOM <= {$urandom, $urandom};
    #1;
    chk_wr(GPR_WR, eg);
    chk_wr(FPR_WR, ef);
    chk_w({29'h0, EXC, FP_CAUSE_WE}, {29'h0, ee, 1'b0});
    if (eg.en) last = eg.data[31:0];
  endtask

  initial begin
    logic [31:0]         i, d;
    logic [1:0]          r;
    logic                p;
    mfmove_pkg::reg_wr_t eg, ef, z;
    int                  k, c;
    {RESET, INSTR_VALID, INSTR, PROD_UPPER, PROD_BOTTOM} = '0;
    RESET = 1'b1;
    {AWADDR, WDATA, AWVALID, WVALID, BREADY, ARADDR, ARVALID, RREADY} = '0;
    WSTRB = 4'hF;
    {error_cnt, checks, cyc, last} = '0;
    z = '0;
    void'($urandom(15535));
    for (k = 0; k < 256; k++) pm_u.sc[k] = {$urandom, $urandom};
    for (k = 0; k < 32; k++) pm_u.fp[k] = {$urandom, $urandom};
    for (k = 0; k < 32; k++) pm_u.cc[k] = {$urandom, $urandom};
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    // reset values, unmapped place last
    for (k = 0; k < 5; k++) begin
      rd(8'(4 * k), d, r);
      chk_w(d, (k == 0) ? {27'h0, mfmove_pkg::CTRL_RESET} : 32'h0);
      chk_w({30'h0, r}, {30'h0, (k == 4) ? mfmove_pkg::RESP_SLVERR : mfmove_pkg::RESP_OKAY});
    end
    // wide fp mode so paired copies are legal
    wr(mfmove_pkg::ADDR_CTRL, 32'h1F, r);
    for (k = 0; k < 60; k++) begin
      build((k < 10) ? k : int'($urandom % 10), i, eg, ef);
      do_op(i, eg, ef, 2'h0);
    end
    // all coprocessors off
    wr(mfmove_pkg::ADDR_CTRL, 32'h10, r);
    for (k = 0; k < 10; k++) begin
      p = (k == 5 || k == 6);
      build(k, i, eg, ef);
      do_op(i, p ? eg : z, z, p ? 2'h0 : 2'h1);
    end
    // upper moves before second release, with and without coprocessors
    for (c = 0; c < 2; c++) begin
      wr(mfmove_pkg::ADDR_CTRL, c ? 32'h0 : 32'h0F, r);
      for (k = 2; k < 5; k += 2) begin
        build(k, i, eg, ef);
        do_op(i, z, z, 2'h2);
      end
    end
    wr(mfmove_pkg::ADDR_CTRL, 32'h1F, r);
    do_op({mfmove_pkg::OPC_FPU, 5'h14, 5'h00, 5'h03, 5'h04, mfmove_pkg::FN_FMOV}, z, z, 2'h2);
    // status, mask and interrupt line
    rd(mfmove_pkg::ADDR_STAT, d, r);
    chk_w(d, 32'h7);
    chk_w({31'h0, IRQ}, 32'h0);
    wr(mfmove_pkg::ADDR_MASK, 32'h2, r);
    chk_w({31'h0, IRQ}, 32'h1);
    wr(mfmove_pkg::ADDR_STAT, 32'h2, r);
    chk_w({31'h0, IRQ}, 32'h0);
    rd(mfmove_pkg::ADDR_STAT, d, r);
    chk_w(d, 32'h5);
    // lane zero off leaves the mask alone
    WSTRB <= 4'h0;
    wr(mfmove_pkg::ADDR_MASK, 32'h7, r);
    WSTRB <= 4'hF;
    rd(mfmove_pkg::ADDR_MASK, d, r);
    chk_w(d, 32'h2);
    // read-only place keeps last integer write
    wr(mfmove_pkg::ADDR_LAST, 32'hFFFFFFFF, r);
    chk_w({30'h0, r}, {30'h0, mfmove_pkg::RESP_OKAY});
    rd(mfmove_pkg::ADDR_LAST, d, r);
    chk_w(d, last);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
